//--- rrtc_core.v
/*
 * receive/transmit control of a low-rate radio: state command, send pin,
 * frame start/done events, link quality, energy and checksum status,
 * transmit power register, AHB-Lite slave, receive data FIFO.
 * assumes the demodulator delivers bytes with a strobe on I_CLOCK, that
 * the analog side supplies rssi and quality estimates, and that the
 * send pin and the link strobes come from outside this clock domain.
 */
// Register access over AHB-Lite was chosen for this implementation.
// Functional notes
// [RULE1] basic mode: pulse frame start event on a received start delimiter
// [RULE2] basic mode: pulse frame done event when reception ends
// [RULE3] link quality byte is appended after stored frame data
// [RULE4] energy and checksum status readable after reception
// [RULE5] received data bytes are written into the frame buffer
// [RULE6] frequency offset captured at sync and applied for the frame
// [RULE7] rssi arrives quantised in 3 dB steps
// [RULE8] host writes listen or auto-ack listen command to enable receive
// [RULE9] basic mode receives with no extra setup; extended needs mode setup
// [RULE10] extended mode filters destination address, flags pending data; code stores every frame, address match only gates O_PENDING
// [RULE11] send command or send pin rising edge from idle starts sending
// [RULE12] extended modes start transmissions automatically per phase
// [RULE13] transmit path fetches bytes from the buffer for modulation
// [RULE14] bit 7 of power register is auto checksum enable, bits 6:4 zero
// [RULE15] bits 3:0 select one of sixteen power steps, reset 0x0
// [RULE16] buffer overwritten 32 us after frame start even if masked
// [RULE17] new power level takes effect at next transmission start
`include "rrtc_map.vh"
module rrtc_core (
    input wire I_CLOCK,
    input wire I_SRST,
    input wire I_HSEL,
    input wire [7:0] I_HADDR,
    input wire [1:0] I_HTRANS,
    input wire I_HWRITE,
    input wire [2:0] I_HSIZE,
    input wire [31:0] I_HWDATA,
    input wire I_HREADY,
    output reg [31:0] O_HRDATA,
    output reg O_HREADYOUT,
    output reg O_HRESP,
    input wire I_SEND_PIN,
    input wire I_SYNC_DET,
    input wire I_RX_BYTE_VALID,
    input wire [7:0] I_RX_BYTE,
    input wire I_RX_END,
    input wire I_CHECKSUM_OK,
    input wire [4:0] I_RSSI,
    input wire [7:0] I_QUALITY,
    input wire [7:0] I_FREQ_OFS,
    input wire I_TX_READY,
    input wire I_ACK_REQ,
    output reg O_TX_VALID,
    output reg [7:0] O_TX_BYTE,
    output reg [3:0] O_TX_POWER,
    output reg O_TX_AUTO_CHECKSUM,
    output reg [7:0] O_FREQ_CORR,
    output reg O_RX_ENABLE,
    output reg O_FRAME_START,
    output reg O_FRAME_DONE,
    output reg O_PENDING
);
    // ------------------------------------------------------------------------
    // state codes
    // ------------------------------------------------------------------------
    localparam ST_IDLE = 3'd0;
    localparam ST_LISTEN = 3'd1;
    localparam ST_WAIT = 3'd2;
    localparam ST_STORE = 3'd3;
    localparam ST_SEND = 3'd4;
    localparam integer STORE_CYC_I = `RRTC_STORE_CYC;
    localparam [15:0] STORE_CYC = STORE_CYC_I[15:0];

    function is_listen;
        input [2:0] s;
        begin
            is_listen = (s == ST_LISTEN) || (s == ST_WAIT) || (s == ST_STORE);
        end
    endfunction

    // ------------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------------
    reg [5:0] s1_q;
    reg [5:0] s2_q;
    reg pin_q;
    reg [7:0] rxb1_q;
    reg [7:0] rxb2_q;
    reg rx_bv_q;
    always @(posedge I_CLOCK) begin
        if (I_SRST) begin
            s1_q <= 6'h00;
            s2_q <= 6'h00;
            pin_q <= 1'b0;
            rxb1_q <= 8'h00;
            rxb2_q <= 8'h00;
            rx_bv_q <= 1'b0;
        end else begin
            s1_q <= {I_ACK_REQ, I_TX_READY, I_RX_END, I_RX_BYTE_VALID, I_SYNC_DET,
                     I_SEND_PIN};
            s2_q <= s1_q;
            pin_q <= s2_q[0];
            rxb1_q <= I_RX_BYTE;
            rxb2_q <= rxb1_q;
            rx_bv_q <= s2_q[2];
        end
    end
    wire pin_rise = s2_q[0] && !pin_q;
    wire sync_det = s2_q[1];
    wire rx_bv = s2_q[2];
    // byte strobe stands several cycles: store once, on its rising edge
    wire rx_bv_rise = rx_bv && !rx_bv_q;
    wire rx_end = s2_q[3];
    wire tx_rdy = s2_q[4];
    wire ack_req = s2_q[5];

    // ------------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------------
    reg wr_pend_q;
    reg [7:0] wr_addr_q;
    reg [7:0] txpwr_q;
    reg [7:0] mode_q;
    reg [4:0] cmd_q;
    reg cmd_stb_q;
    reg [7:0] energy_q;
    reg chk_ok_q;
    reg [2:0] st_q;
    reg [2:0] st_d;
    wire [7:0] f_out_data;
    wire f_out_valid;
    wire [5:0] f_count;
    wire addr_ok = I_HSEL && I_HREADY && I_HTRANS[1];
    wire rd_fifo = addr_ok && !I_HWRITE && (I_HADDR == `RRTC_ADDR_FIFO);
    reg [31:0] rd_d;

    always @* begin
        rd_d = 32'h00000000;
        case (I_HADDR)
            `RRTC_ADDR_STATE: rd_d = {24'h000000, st_q, cmd_q};
            `RRTC_ADDR_TXPWR: rd_d = {24'h000000, txpwr_q & `RRTC_TXPWR_MASK}; // RULE14
            `RRTC_ADDR_CHKSUM: rd_d = {24'h000000, chk_ok_q, 7'h00}; // RULE4
            `RRTC_ADDR_ENERGY: rd_d = {24'h000000, energy_q}; // RULE4
            `RRTC_ADDR_STATUS: rd_d = {26'h0000000, f_count};
            `RRTC_ADDR_FIFO: rd_d = {23'h000000, f_out_valid, f_out_data};
            `RRTC_ADDR_MODE: rd_d = {24'h000000, mode_q};
            default: rd_d = 32'h00000000;
        endcase
    end

    always @(posedge I_CLOCK) begin
        if (I_SRST) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            O_HRDATA <= 32'h00000000;
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
            txpwr_q <= `RRTC_TXPWR_RST;
            mode_q <= 8'h00;
            cmd_q <= `RRTC_CMD_NOP;
            cmd_stb_q <= 1'b0;
        end else begin
            cmd_stb_q <= 1'b0;
            wr_pend_q <= addr_ok && I_HWRITE;
            wr_addr_q <= I_HADDR;
            if (addr_ok && !I_HWRITE) begin
                O_HRDATA <= rd_d;
            end
            if (wr_pend_q) begin
                case (wr_addr_q)
                    `RRTC_ADDR_STATE: begin
                        cmd_q <= I_HWDATA[`RRTC_CMD_MSB:0]; // RULE8
                        cmd_stb_q <= 1'b1;
                    end
                    `RRTC_ADDR_TXPWR: txpwr_q <= I_HWDATA[7:0] & `RRTC_TXPWR_MASK; // RULE15
                    `RRTC_ADDR_MODE: mode_q <= I_HWDATA[7:0];
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // receive data path and FIFO
    // ------------------------------------------------------------------------
    reg f_in_valid;
    reg [7:0] f_in_data;
    wire f_in_ready;
    reg lqi_pend_q;
    reg [15:0] wait_q;
    wire addr_match = (mode_q == 8'h00) || (rxb2_q == mode_q);
    // transmit pops the buffer; a bus pop in the same cycle takes priority
    wire tx_take = (st_q == ST_SEND) && tx_rdy && !O_TX_VALID && f_out_valid && !rd_fifo;

    rrtc_fifo #(
        .WIDTH(8),
        .DEPTH(`RRTC_FIFO_DEPTH),
        .AW(`RRTC_FIFO_AW)
    ) u_fifo (
        .i_clk(I_CLOCK),
        .i_srst(I_SRST),
        .i_in_valid(f_in_valid),
        .o_in_ready(f_in_ready),
        .i_in_data(f_in_data),
        .o_out_valid(f_out_valid),
        .i_out_ready(rd_fifo || tx_take),
        .o_out_data(f_out_data),
        .o_count(f_count)
    );

    always @* begin
        f_in_valid = 1'b0;
        f_in_data = rxb2_q;
        if (lqi_pend_q) begin
            f_in_valid = 1'b1;
            f_in_data = I_QUALITY; // RULE3
        end else if (st_q == ST_STORE && rx_bv_rise) begin
            f_in_valid = 1'b1; // RULE5
        end
    end

    // ------------------------------------------------------------------------
    // control state machine
    // ------------------------------------------------------------------------
    wire start_tx = (cmd_stb_q && cmd_q == `RRTC_CMD_SEND) || pin_rise; // RULE11
    wire ext_mode = (cmd_q == `RRTC_CMD_AALISTEN) || (cmd_q == `RRTC_CMD_ARETRY);

    always @* begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (start_tx) begin
                    st_d = ST_SEND;
                end else if (cmd_stb_q && (cmd_q == `RRTC_CMD_LISTEN ||
                                           cmd_q == `RRTC_CMD_AALISTEN)) begin
                    st_d = ST_LISTEN; // RULE9
                end else if (cmd_stb_q && cmd_q == `RRTC_CMD_ARETRY) begin
                    st_d = ST_SEND; // RULE12
                end
            end
            ST_LISTEN: begin
                if (cmd_stb_q && cmd_q == `RRTC_CMD_IDLE) begin
                    st_d = ST_IDLE;
                end else if (sync_det) begin
                    st_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (wait_q == STORE_CYC) begin
                    st_d = ST_STORE; // RULE16
                end
            end
            ST_STORE: begin
                if (rx_end) begin
                    st_d = (ext_mode && ack_req) ? ST_SEND : ST_LISTEN; // RULE12
                end
            end
            ST_SEND: begin
                if (!f_out_valid && !O_TX_VALID) begin
                    st_d = (cmd_q == `RRTC_CMD_ARETRY) ? ST_LISTEN : ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always @(posedge I_CLOCK) begin
        if (I_SRST) begin
            st_q <= ST_IDLE;
            wait_q <= 16'h0000;
            lqi_pend_q <= 1'b0;
            energy_q <= 8'h00;
            chk_ok_q <= 1'b0;
            O_TX_VALID <= 1'b0;
            O_TX_BYTE <= 8'h00;
            O_TX_POWER <= 4'h0;
            O_TX_AUTO_CHECKSUM <= 1'b0;
            O_FREQ_CORR <= 8'h00;
            O_RX_ENABLE <= 1'b0;
            O_FRAME_START <= 1'b0;
            O_FRAME_DONE <= 1'b0;
            O_PENDING <= 1'b0;
        end else begin
            st_q <= st_d;
            O_RX_ENABLE <= is_listen(st_d);
            O_FRAME_START <= (st_q == ST_LISTEN) && sync_det && !ext_mode; // RULE1
            O_FRAME_DONE <= (st_q == ST_STORE) && rx_end && !ext_mode; // RULE2
            lqi_pend_q <= (st_q == ST_STORE) && rx_end && f_in_ready;
            wait_q <= (st_q == ST_WAIT) ? wait_q + 16'h0001 : 16'h0000;
            if (st_q == ST_LISTEN && sync_det) begin
                O_FREQ_CORR <= I_FREQ_OFS; // RULE6
            end
            if (st_q == ST_STORE && rx_end) begin
                energy_q <= {3'b000, I_RSSI}; // RULE7
                chk_ok_q <= I_CHECKSUM_OK; // RULE4
                O_PENDING <= ext_mode && addr_match && I_CHECKSUM_OK; // RULE10
            end
            if (st_q != ST_SEND && st_d == ST_SEND) begin
                O_TX_POWER <= txpwr_q[3:0]; // RULE17
                O_TX_AUTO_CHECKSUM <= txpwr_q[`RRTC_CHK_BIT]; // RULE14
            end
            if (tx_take) begin
                O_TX_VALID <= 1'b1;
                O_TX_BYTE <= f_out_data; // RULE13
            end else begin
                O_TX_VALID <= 1'b0;
            end
        end
    end
endmodule

//--- rrtc_map.vh
/*
 * register offsets, field positions, reset values, state commands and timing
 * counts for the radio receive/transmit control block.
 * assumes a 50 MHz system clock and 32-bit AHB-Lite register access.
 */
`ifndef RRTC_MAP_VH
`define RRTC_MAP_VH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define RRTC_ADDR_STATE   8'h08
`define RRTC_ADDR_TXPWR   8'h14
`define RRTC_ADDR_CHKSUM  8'h18
`define RRTC_ADDR_ENERGY  8'h1C
`define RRTC_ADDR_STATUS  8'h40
`define RRTC_ADDR_FIFO    8'h44
`define RRTC_ADDR_MODE    8'h48

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define RRTC_TXPWR_RST    8'h00
`define RRTC_TXPWR_MASK   8'h8F
`define RRTC_CHK_BIT      7
`define RRTC_CMD_MSB      4
`define RRTC_CMD_W        5

// ----------------------------------------------------------------------------
// state commands
// ----------------------------------------------------------------------------
`define RRTC_CMD_NOP      5'h00
`define RRTC_CMD_SEND     5'h02
`define RRTC_CMD_IDLE     5'h08
`define RRTC_CMD_LISTEN   5'h06
`define RRTC_CMD_AALISTEN 5'h16
`define RRTC_CMD_ARETRY   5'h19

// ----------------------------------------------------------------------------
// timing: store delay after frame start, in ns, and its cycle count
// ----------------------------------------------------------------------------
`define RRTC_CLK_NS       20
`define RRTC_STORE_NS     32000
`define RRTC_STORE_CYC    ((`RRTC_STORE_NS + `RRTC_CLK_NS - 1) / `RRTC_CLK_NS)
`define RRTC_SFD          8'hA7
`define RRTC_FIFO_DEPTH   32
`define RRTC_FIFO_AW      5

`endif

//--- rrtc_fifo.v
/*
 * parameterised synchronous FIFO with valid/ready on both sides.
 * assumes one clock and a synchronous active-high reset.
 */
module rrtc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire i_clk,
    input wire i_srst,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data,
    output wire [AW:0] o_count
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    assign o_in_ready = (cnt_q != DEPTH[AW:0]);
    assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
    assign o_out_data = mem[rd_q];
    assign o_count = cnt_q;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always @(posedge i_clk) begin
        if (push) begin
            mem[wr_q] <= i_in_data;
        end
        if (i_srst) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

//--- rrtc_checker.sv
/* port assertions for rrtc_core.
   assumes one clock, synchronous active-high reset. */
`include "rrtc_map.vh"
module rrtc_checker (
    input wire I_CLOCK,
    input wire I_SRST,
    input wire I_HSEL,
    input wire [7:0] I_HADDR,
    input wire [1:0] I_HTRANS,
    input wire I_HWRITE,
    input wire I_HREADY,
    input wire [31:0] I_HWDATA,
    input wire [31:0] O_HRDATA,
    input wire O_HREADYOUT,
    input wire O_HRESP,
    input wire I_SYNC_DET,
    input wire I_RX_END,
    input wire O_RX_ENABLE,
    input wire O_FRAME_START,
    input wire O_FRAME_DONE
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // address decode and state command tracking
    // ----------------------------------------------------------------
    wire take = I_HSEL && I_HREADY && I_HTRANS[1];
    wire hit = I_HADDR == `RRTC_ADDR_STATE || I_HADDR == `RRTC_ADDR_TXPWR
        || I_HADDR == `RRTC_ADDR_CHKSUM || I_HADDR == `RRTC_ADDR_ENERGY
        || I_HADDR == `RRTC_ADDR_STATUS || I_HADDR == `RRTC_ADDR_FIFO
        || I_HADDR == `RRTC_ADDR_MODE;
    logic st_wr_q;
    always @(posedge I_CLOCK) begin
        st_wr_q <= !I_SRST && take && I_HWRITE && I_HADDR == `RRTC_ADDR_STATE;
    end
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_SRST);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    ready_okay_a: assert property (O_HREADYOUT && !O_HRESP)
        else $error("slave not ready or response not okay");
    unmapped_zero_a: assert property (take && !I_HWRITE && !hit |=> O_HRDATA == 32'h0)
        else $error("unmapped read not zero");
    power_resv_a: assert property (take && !I_HWRITE && I_HADDR == `RRTC_ADDR_TXPWR
        |=> O_HRDATA[31:8] == 24'h0 && O_HRDATA[6:4] == 3'h0) else $error("reserved bits set");
    listen_en_a: assert property (st_wr_q && I_HWDATA[4:0] == `RRTC_CMD_LISTEN
        |-> ##[1:4] O_RX_ENABLE) else $error("listen did not enable receive");
    ext_listen_a: assert property (st_wr_q && I_HWDATA[4:0] == `RRTC_CMD_AALISTEN
        |-> ##[1:4] O_RX_ENABLE) else $error("auto-ack listen did not enable receive");
    start_pulse_a: assert property (O_FRAME_START |=> !O_FRAME_START)
        else $error("frame start longer than one cycle");
    done_pulse_a: assert property (O_FRAME_DONE |=> !O_FRAME_DONE)
        else $error("frame done longer than one cycle");
    start_cause_a: assert property (O_FRAME_START |-> $past(I_SYNC_DET, 3))
        else $error("frame start without delimiter");
    done_cause_a: assert property (O_FRAME_DONE |-> $past(I_RX_END, 3))
        else $error("frame done without frame end");
    cover property (O_FRAME_START);
    cover property (O_FRAME_DONE);
    cover property (st_wr_q && I_HWDATA[4:0] == `RRTC_CMD_SEND);
endmodule
bind rrtc_core rrtc_checker u_rrtc_checker (.I_CLOCK(I_CLOCK), .I_SRST(I_SRST),
    .I_HSEL(I_HSEL), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
    .I_HREADY(I_HREADY), .I_HWDATA(I_HWDATA), .O_HRDATA(O_HRDATA),
    .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .I_SYNC_DET(I_SYNC_DET),
    .I_RX_END(I_RX_END), .O_RX_ENABLE(O_RX_ENABLE), .O_FRAME_START(O_FRAME_START),
    .O_FRAME_DONE(O_FRAME_DONE));

//--- rrtc_radio_model.sv
/* far-side radio model: demodulated byte stream and modulator ready.
   assumes it runs on the block's clock. */
module rrtc_radio_model (
    input wire i_clk,
    input wire i_tx_valid,
    output logic o_sync_det = 1'b0,
    output logic o_rx_valid = 1'b0,
    output logic [7:0] o_rx_byte = 8'h00,
    output logic o_rx_end = 1'b0,
    output logic o_crc_ok = 1'b0,
    output logic [4:0] o_rssi = 5'h00,
    output logic [7:0] o_quality = 8'h00,
    output logic [7:0] o_freq_ofs = 8'h00,
    output logic o_tx_ready = 1'b1
);
    timeunit 1ns;
    timeprecision 1ns;
    logic slow = 1'b0;
    // ----------------------------------------------------------------
    // modulator ready: stalls every other cycle when slow
    // ----------------------------------------------------------------
    always @(posedge i_clk) begin
        o_tx_ready <= !slow || !o_tx_ready;
    end
    // one frame; byte line shows the inverse between bytes
    task automatic rx_frame(input int n, input logic [7:0] b[32], input logic [7:0] lq,
        input logic ok, input logic [4:0] rs);
        o_sync_det <= 1'b1;
        o_quality <= lq;
        o_rssi <= rs;
        o_crc_ok <= ok;
        o_freq_ofs <= 8'h3C;
        repeat (1700) @(posedge i_clk);
        for (int i = 0; i < n; i++) begin
            o_rx_byte <= b[i];
            o_rx_valid <= 1'b1;
            repeat (3) @(posedge i_clk);
            o_rx_valid <= 1'b0;
            o_rx_byte <= ~b[i];
            repeat (2) @(posedge i_clk);
        end
        o_rx_end <= 1'b1;
        o_sync_det <= 1'b0;
        repeat (3) @(posedge i_clk);
        o_rx_end <= 1'b0;
    endtask
endmodule

//--- tb_radio_rx_tx_control.sv
/* self-checking bench for rrtc_core with a queue model of the buffer.
   assumes the radio model above and the register map header. */
`include "rrtc_map.vh"
module tb_radio_rx_tx_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, pin = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, r, v;
    wire [31:0] hrdata;
    wire hready, sync, rxv, rxe, crc, txv, txr, rxen, fst, fdn, txac, pend;
    wire [7:0] rxb, lq, fo, txb, fcorr;
    wire [4:0] rssi;
    wire [3:0] txp;
    int n_fail = 0, comparisons = 0, n_st = 0, n_dn = 0, cyc = 0, q[$];
    integer seed = 32'hdd41f80c;
    rrtc_core u_rrtc_core (.I_CLOCK(clk), .I_SRST(srst), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
        .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(),
        .I_SEND_PIN(pin), .I_SYNC_DET(sync), .I_RX_BYTE_VALID(rxv), .I_RX_BYTE(rxb),
        .I_RX_END(rxe), .I_CHECKSUM_OK(crc), .I_RSSI(rssi), .I_QUALITY(lq),
        .I_FREQ_OFS(fo), .I_TX_READY(txr), .I_ACK_REQ(1'b0), .O_TX_VALID(txv),
        .O_TX_BYTE(txb), .O_TX_POWER(txp), .O_TX_AUTO_CHECKSUM(txac), .O_FREQ_CORR(fcorr),
        .O_RX_ENABLE(rxen), .O_FRAME_START(fst), .O_FRAME_DONE(fdn), .O_PENDING(pend));
    rrtc_radio_model u_rrtc_radio_model (.i_clk(clk), .i_tx_valid(txv), .o_sync_det(sync),
        .o_rx_valid(rxv), .o_rx_byte(rxb), .o_rx_end(rxe), .o_crc_ok(crc), .o_rssi(rssi),
        .o_quality(lq), .o_freq_ofs(fo), .o_tx_ready(txr));
    initial begin
        forever #10 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // event counting and hang limit
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (fst === 1'b1) n_st++;
        if (fdn === 1'b1) n_dn++;
        if (txv === 1'b1) chk("tx byte", q.pop_front(), txb);
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // single AHB-Lite word transfer
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, e, r);
    endtask
    task automatic frame(input int n, input logic ok, input bit drain);
        logic [7:0] b[32];
        logic [7:0] l;
        logic [4:0] s;
        int st, dn;
        foreach (b[i]) b[i] = $random(seed);
        l = $random(seed);
        s = $random(seed);
        for (int i = 0; i < n; i++) q.push_back(b[i]);
        q.push_back(l);
        st = n_st;
        dn = n_dn;
        @(posedge clk);
        u_rrtc_radio_model.rx_frame(n, b, l, ok, s);
        for (int k = 0; k < 20 && n_dn == dn; k++) @(posedge clk);
        repeat (2) @(posedge clk);
        chk("start events", 1, n_st - st);
        chk("done events", 1, n_dn - dn);
        chk("freq corr", fo, fcorr);
        chk("pending", 0, pend);
        rd(`RRTC_ADDR_STATUS, q.size(), "stored count");
        if (drain) begin
            while (q.size() > 0) rd(`RRTC_ADDR_FIFO, 32'h100 | q.pop_front(), "rx byte");
            bus(1'b0, `RRTC_ADDR_FIFO, 32'h0);
            chk("empty pop", 0, r[8]);
        end
        rd(`RRTC_ADDR_ENERGY, {27'h0, s}, "energy");
        bus(1'b0, `RRTC_ADDR_CHKSUM, 32'h0);
        chk("checksum ok", ok, r[7]);
    endtask
    task automatic wait_tx(input logic [4:0] e, input string nm);
        for (int k = 0; k < 20 && {txac, txp} !== e; k++) @(posedge clk);
        chk(nm, e, {txac, txp});
    endtask
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rd(`RRTC_ADDR_TXPWR, 32'h0, "power reset");
        for (int i = 0; i < 16; i++) begin
            v = ($random(seed) & 32'hF0) | i;
            bus(1'b1, `RRTC_ADDR_TXPWR, v);
            rd(`RRTC_ADDR_TXPWR, v & 32'h8F, "power readback");
        end
        bus(1'b1, 8'h3C, 32'hFF);
        rd(8'h3C, 32'h0, "unmapped read");
        rd(`RRTC_ADDR_TXPWR, v & 32'h8F, "power kept");
        $display("register test done");
        bus(1'b1, `RRTC_ADDR_STATE, `RRTC_CMD_AALISTEN);
        repeat (4) @(posedge clk);
        chk("ext listen enable", 1, rxen);
        bus(1'b1, `RRTC_ADDR_STATE, `RRTC_CMD_IDLE);
        bus(1'b1, `RRTC_ADDR_STATE, `RRTC_CMD_LISTEN);
        repeat (4) @(posedge clk);
        chk("listen enable", 1, rxen);
        frame(5, 1'b1, 1'b1);
        frame(31, 1'b0, 1'b1);
        frame(4, 1'b1, 1'b0);
        $display("receive test done");
        bus(1'b1, `RRTC_ADDR_STATE, `RRTC_CMD_IDLE);
        bus(1'b1, `RRTC_ADDR_TXPWR, 32'h85);
        u_rrtc_radio_model.slow = 1'b1;
        bus(1'b1, `RRTC_ADDR_STATE, `RRTC_CMD_SEND);
        wait_tx(5'h15, "send command setting");
        bus(1'b1, `RRTC_ADDR_TXPWR, 32'h0A);
        chk("setting held", 5'h15, {txac, txp});
        repeat (20) @(posedge clk);
        chk("tx drained", 0, q.size());
        bus(1'b1, `RRTC_ADDR_STATE, `RRTC_CMD_IDLE);
        pin <= 1'b1;
        wait_tx(5'h0A, "send pin setting");
        pin <= 1'b0;
        bus(1'b1, `RRTC_ADDR_STATE, `RRTC_CMD_ARETRY);
        repeat (4) @(posedge clk);
        chk("auto retry listen", 1, rxen);
        $display("transmit test done");
        print_verdict();
    end
endmodule
